// ===== common/xas_pkg.sv
`default_nettype none
package xas_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] XAS_ADDR_INTERNAL_EXPANSION_RAM_PAGE    = 8'h91;
    localparam logic [7:0] XAS_ADDR_SYSTEM_CTRL  = 8'hB1;
    localparam logic [7:0] XAS_ADDR_POINTER_SEL  = 8'h92;
    localparam logic [7:0] XAS_ADDR_DATA_POINTER_LOW     = 8'h82;
    localparam logic [7:0] XAS_ADDR_DATA_POINTER_HIGH    = 8'h83;
    localparam int         XAS_DISABLE_BIT_POS   = 0;
    localparam int         XAS_VISIBLE_BIT_POS   = 1;
    localparam logic [7:0] XAS_SYSCTRL_RESET     = 8'hA1;
    localparam logic [7:0] XAS_PAGE_RESET        = 8'h00;
    localparam logic [2:0] XAS_PSEL_RESET        = 3'h0;
    localparam logic [15:0] XAS_DATA_POINTER_RESET       = 16'h0000;
    localparam int         XAS_NUM_DATA_POINTER          = 8;
    // lowest internal ram address; top of range is FFFF
    localparam logic [15:0] XAS_INTERNAL_EXPANSION_RAM_BASE        = 16'hF700;
    localparam logic [15:0] XAS_INTERNAL_EXPANSION_RAM_TOP         = 16'hFFFF;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        use_ptr;
        logic [7:0]  reg_addr;
        logic [7:0]  wdata;
    } xas_move_t;

    typedef struct packed {
        logic        use_internal_expansion_ram;
        logic        rd_n;
        logic        wr_n;
        logic        p0_bus;
        logic        p2_bus;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        write;
    } xas_route_t;
endpackage
`default_nettype wire

// ===== hw/xas_data_pointer_bank.sv
`default_nettype none
module xas_data_pointer_bank
    import xas_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [2:0]  sel_in,
    input  wire logic        wr_low_in,
    input  wire logic        wr_high_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [15:0] data_pointer_out
);
    logic [15:0] ptr_ff [XAS_NUM_DATA_POINTER];
    logic [15:0] nxt_ptr [XAS_NUM_DATA_POINTER];

    always_comb
    begin
        for (int i = 0; i < XAS_NUM_DATA_POINTER; i++)
        begin
            nxt_ptr[i] = ptr_ff[i];
        end
        if (wr_low_in)
        begin
            nxt_ptr[sel_in][7:0] = wdata_in;
        end
        if (wr_high_in)
        begin
            nxt_ptr[sel_in][15:8] = wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            for (int i = 0; i < XAS_NUM_DATA_POINTER; i++)
            begin
                ptr_ff[i] <= XAS_DATA_POINTER_RESET;
            end
        end
        else
        begin
            for (int i = 0; i < XAS_NUM_DATA_POINTER; i++)
            begin
                ptr_ff[i] <= nxt_ptr[i];
            end
        end
    end

    // only the selected pointer is ever seen by the move logic
    assign data_pointer_out = ptr_ff[sel_in];
endmodule
`default_nettype wire

// ===== hw/xas_steering.sv
`default_nettype none
module xas_steering
    import xas_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        ext_access_pin_low_in,
    input  wire xas_move_t   move_in,
    output xas_route_t       route_out,
    output logic      [15:0] active_data_pointer_out
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  sysctrl_ff;
    logic [7:0]  nxt_sysctrl;
    logic [7:0]  page_ff;
    logic [7:0]  nxt_page;
    logic [2:0]  psel_ff;
    logic [2:0]  nxt_psel;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    xas_route_t  route_ff;
    xas_route_t  nxt_route;
    logic [15:0] adptr_ff;
    logic [15:0] nxt_adptr;
    logic [15:0] data_pointer;
    logic        wr_low;
    logic        wr_high;

    assign wr_low  = reg_wr_in && (reg_addr_in == XAS_ADDR_DATA_POINTER_LOW);
    assign wr_high = reg_wr_in && (reg_addr_in == XAS_ADDR_DATA_POINTER_HIGH);

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic        wr_sysctrl;
    logic        wr_page;
    logic        wr_psel;
    logic        rd_sysctrl;
    logic        rd_page;
    logic        rd_psel;
    logic        rd_data_pointer_low;
    logic        rd_data_pointer_high;

    assign wr_sysctrl   = reg_wr_in && (reg_addr_in == XAS_ADDR_SYSTEM_CTRL);
    assign wr_page      = reg_wr_in && (reg_addr_in == XAS_ADDR_INTERNAL_EXPANSION_RAM_PAGE);
    assign wr_psel      = reg_wr_in && (reg_addr_in == XAS_ADDR_POINTER_SEL);
    assign rd_sysctrl   = reg_rd_in && (reg_addr_in == XAS_ADDR_SYSTEM_CTRL);
    assign rd_page      = reg_rd_in && (reg_addr_in == XAS_ADDR_INTERNAL_EXPANSION_RAM_PAGE);
    assign rd_psel      = reg_rd_in && (reg_addr_in == XAS_ADDR_POINTER_SEL);
    assign rd_data_pointer_low  = reg_rd_in && (reg_addr_in == XAS_ADDR_DATA_POINTER_LOW);
    assign rd_data_pointer_high = reg_rd_in && (reg_addr_in == XAS_ADDR_DATA_POINTER_HIGH);

    xas_data_pointer_bank u_bank
    (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .sel_in     (psel_ff),
        .wr_low_in  (wr_low),
        .wr_high_in (wr_high),
        .wdata_in   (reg_wdata_in),
        .data_pointer_out   (data_pointer)
    );

    // ------------------------------------------------------------
    // system control: disable and visibility bits
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_sysctrl = sysctrl_ff;
        if (wr_sysctrl)
        begin
            // other bits are plain storage
            nxt_sysctrl = reg_wdata_in;
            // a cleared disable bit stays clear until reset, so a stray
            // write cannot pull internal ram away from running code
            nxt_sysctrl[XAS_DISABLE_BIT_POS] =
                sysctrl_ff[XAS_DISABLE_BIT_POS]
                & reg_wdata_in[XAS_DISABLE_BIT_POS];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sysctrl_ff <= XAS_SYSCTRL_RESET;
        end
        else
        begin
            sysctrl_ff <= nxt_sysctrl;
        end
    end

    // ------------------------------------------------------------
    // page register for register-indirect moves
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_page = page_ff;
        if (wr_page)
        begin
            nxt_page = reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            page_ff <= XAS_PAGE_RESET;
        end
        else
        begin
            page_ff <= nxt_page;
        end
    end

    // ------------------------------------------------------------
    // pointer select
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_psel = psel_ff;
        if (wr_psel)
        begin
            nxt_psel = reg_wdata_in[2:0];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            psel_ff <= XAS_PSEL_RESET;
        end
        else
        begin
            psel_ff <= nxt_psel;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb
    begin
        // idle and unmapped cycles read as zero
        nxt_rdata = 8'h00;
        if (rd_sysctrl)
        begin
            nxt_rdata = sysctrl_ff;
        end
        if (rd_page)
        begin
            nxt_rdata = page_ff;
        end
        if (rd_psel)
        begin
            nxt_rdata = {5'h00, psel_ff};
        end
        if (rd_data_pointer_low)
        begin
            nxt_rdata = data_pointer[7:0];
        end
        if (rd_data_pointer_high)
        begin
            nxt_rdata = data_pointer[15:8];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // access steering
    // ------------------------------------------------------------
    logic        dis;
    logic        vis;
    logic        hit;
    logic [15:0] eff_addr;

    always_comb
    begin
        dis = sysctrl_ff[XAS_DISABLE_BIT_POS];
        vis = sysctrl_ff[XAS_VISIBLE_BIT_POS];
        // register moves build the address from page and register
        eff_addr = move_in.use_ptr ? data_pointer
                 : {page_ff, move_in.reg_addr};
        hit = (eff_addr >= XAS_INTERNAL_EXPANSION_RAM_BASE)
            && (eff_addr <= XAS_INTERNAL_EXPANSION_RAM_TOP);
        nxt_route = route_ff;
        nxt_route.rd_n = 1'b1;
        nxt_route.wr_n = 1'b1;
        if (move_in.valid)
        begin
            nxt_route.addr     = eff_addr;
            nxt_route.wdata    = move_in.wdata;
            nxt_route.write    = move_in.write;
            nxt_route.use_internal_expansion_ram = hit && !dis;
            if (!hit || dis)
            begin
                // external cycle; visibility has no say here
                nxt_route.p0_bus = 1'b1;
                nxt_route.p2_bus = move_in.use_ptr;
                nxt_route.rd_n   = move_in.write;
                nxt_route.wr_n   = !move_in.write;
            end
            else if (vis)
            begin
                nxt_route.p0_bus = 1'b1;
                nxt_route.p2_bus = move_in.use_ptr;
                nxt_route.rd_n   = move_in.write;
                nxt_route.wr_n   = !move_in.write;
            end
            else
            begin
                // pin low still shows data on the ports, strobes quiet
                nxt_route.p0_bus = ext_access_pin_low_in;
                nxt_route.p2_bus = ext_access_pin_low_in
                                 && move_in.use_ptr;
            end
        end
        else
        begin
            nxt_route.p0_bus = 1'b0;
            nxt_route.p2_bus = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // route register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            route_ff <= '{use_internal_expansion_ram: 1'b0, rd_n: 1'b1, wr_n: 1'b1,
                          p0_bus: 1'b0, p2_bus: 1'b0, addr: 16'h0000,
                          wdata: 8'h00, write: 1'b0};
        end
        else
        begin
            route_ff <= nxt_route;
        end
    end

    // ------------------------------------------------------------
    // active pointer copy
    // ------------------------------------------------------------
    // registered so the output leaves a flip-flop; it lags the select
    // register by one cycle
    always_comb
    begin
        nxt_adptr = data_pointer;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            adptr_ff <= XAS_DATA_POINTER_RESET;
        end
        else
        begin
            adptr_ff <= nxt_adptr;
        end
    end

    assign reg_rdata_out   = rdata_ff;
    assign route_out       = route_ff;
    assign active_data_pointer_out = adptr_ff;
endmodule
`default_nettype wire

// ===== verif/xas_steering_props.sv
`default_nettype none
module xas_steering_props
    import xas_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        ext_access_pin_low_in,
    input wire xas_move_t   move_in,
    input wire xas_route_t  route_out,
    input wire logic [15:0] active_data_pointer_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // route checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    property p_idle_stb;
        !move_in.valid |=> route_out.rd_n && route_out.wr_n;
    endproperty
    a_idle_stb: assert property (p_idle_stb)
        else $error("strobe without a move");
    property p_idle_bus;
        !move_in.valid |=> !route_out.p0_bus && !route_out.p2_bus;
    endproperty
    a_idle_bus: assert property (p_idle_bus)
        else $error("bus ports busy without a move");
    property p_reg_p2;
        move_in.valid && !move_in.use_ptr |=> !route_out.p2_bus;
    endproperty
    a_reg_p2: assert property (p_reg_p2)
        else $error("port 2 taken by a register move");
    property p_ext;
        move_in.valid |=> !route_out.use_internal_expansion_ram |->
            route_out.p0_bus && (route_out.rd_n != route_out.wr_n);
    endproperty
    a_ext: assert property (p_ext)
        else $error("external move lacks bus or strobe");
    property p_quiet;
        move_in.valid |=> route_out.use_internal_expansion_ram && !route_out.p0_bus |->
            route_out.rd_n && route_out.wr_n;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("strobe on hidden internal access");
    property p_dir;
        move_in.valid && move_in.write |=> route_out.rd_n && route_out.write;
    endproperty
    a_dir: assert property (p_dir)
        else $error("read strobe on a write move");
    property p_wdata;
        move_in.valid |=> route_out.wdata == $past(move_in.wdata);
    endproperty
    a_wdata: assert property (p_wdata)
        else $error("move data not carried");
    property p_low;
        move_in.valid && !move_in.use_ptr |=>
            route_out.addr[7:0] == $past(move_in.reg_addr);
    endproperty
    a_low: assert property (p_low)
        else $error("low address byte wrong");
endmodule
bind xas_steering xas_steering_props u_props (.*);
`default_nettype wire

// ===== verif/xas_cpu_model.sv
`default_nettype none
module xas_cpu_model
    import xas_pkg::*;
(
    input  wire logic      clk_in,
    output var  xas_move_t move_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // move issue
    // ------------------------------------------------------------
    initial move_out = '0;
    // one-cycle valid; moves are the only path to data memory
    task automatic issue(input logic w, p, input logic [7:0] ra, wd);
        move_out <= '{1'b1, w, p, ra, wd};
        @(posedge clk_in);
        move_out <= '0;
    endtask
endmodule
`default_nettype wire

// ===== verif/xas_steering_tb.sv
`default_nettype none
module xas_steering_tb
    import xas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in, reset_n_in, reg_wr_in, reg_rd_in, pin;
    logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, sc, pg, v;
    logic [15:0] active_data_pointer_out;
    logic [15:0] ptr [8];
    logic [2:0]  sel;
    logic [31:0] r, q;
    xas_move_t   move;
    xas_route_t  route;
    int          miscompares, comparisons, seed;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    xas_steering dut (.clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .ext_access_pin_low_in(pin), .move_in(move), .route_out(route),
        .active_data_pointer_out);
    xas_cpu_model u_cpu (.clk_in, .move_out(move));
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic check(input logic [63:0] got, exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // bench copy of the registers; disable bit can only fall
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        case (a)
            XAS_ADDR_INTERNAL_EXPANSION_RAM_PAGE:   pg = d;
            XAS_ADDR_SYSTEM_CTRL: sc = d & (sc | ~(8'h01 << 0));
            XAS_ADDR_POINTER_SEL: sel = d[2:0];
            XAS_ADDR_DATA_POINTER_LOW:    ptr[sel][7:0] = d;
            XAS_ADDR_DATA_POINTER_HIGH:   ptr[sel][15:8] = d;
            default: ;
        endcase
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    function automatic xas_route_t exp_route(input logic w, p,
                                             input logic [7:0] ra, wd);
        logic [15:0] a;
        logic        ext, stb, p0;
        a = p ? ptr[sel] : {pg, ra};
        ext = sc[XAS_DISABLE_BIT_POS] | (p ? a < XAS_INTERNAL_EXPANSION_RAM_BASE
            : pg < XAS_INTERNAL_EXPANSION_RAM_BASE[15:8]);
        stb = ext | sc[XAS_VISIBLE_BIT_POS];
        p0 = stb | pin;
        return '{!ext, !(stb & !w), !(stb & w), p0, p & p0, a, wd, w};
    endfunction
    task automatic mv(input logic w, p, input logic [7:0] ra, wd);
        @(posedge clk_in);
        u_cpu.issue(w, p, ra, wd);
        #1 check(route, exp_route(w, p, ra, wd));
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        #200000 miscompares++;
        report_and_stop();
    end
    initial
    begin
        seed = 32'h251DA403;
        {reset_n_in, reg_wr_in, reg_rd_in, pin} = 4'h0;
        {reg_addr_in, reg_wdata_in} = 16'h0000;
        {sc, pg, sel} = {XAS_SYSCTRL_RESET, XAS_PAGE_RESET, XAS_PSEL_RESET};
        foreach (ptr[k]) ptr[k] = XAS_DATA_POINTER_RESET;
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(XAS_ADDR_SYSTEM_CTRL, v);
        check(v, 8'hA1);
        rd(XAS_ADDR_INTERNAL_EXPANSION_RAM_PAGE, v);
        check(v, 8'h00);
        wr(8'h55, 8'hFF);
        rd(8'h55, v);
        check(v, 8'h00);
        for (int j = 0; j < 2; j++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                wr(XAS_ADDR_POINTER_SEL, {5'h1F, k[2:0]});
                rd(XAS_ADDR_POINTER_SEL, v);
                check(v, {5'h00, k[2:0]});
                wr(XAS_ADDR_DATA_POINTER_HIGH, 8'hF6 + {7'h00, k[0]});
                wr(XAS_ADDR_DATA_POINTER_LOW, k[0] ? 8'h00 : 8'hFF);
                mv(k[1], 1'b1, 8'h00, k[7:0]);
                check(active_data_pointer_out, ptr[k]);
            end
            wr(XAS_ADDR_SYSTEM_CTRL, 8'hA0);
        end
        for (int i = 0; i < 300; i++)
        begin
            r = $random(seed);
            q = $random(seed);
            wr(XAS_ADDR_SYSTEM_CTRL, r[7:0] | {7'h00, i < 40});
            wr(XAS_ADDR_INTERNAL_EXPANSION_RAM_PAGE, r[16] ? 8'hF0 | r[15:8] : r[15:8]);
            wr(XAS_ADDR_POINTER_SEL, {5'h00, r[19:17]});
            wr(XAS_ADDR_DATA_POINTER_HIGH, r[20] ? 8'hF0 | r[27:24] : r[27:20]);
            wr(XAS_ADDR_DATA_POINTER_LOW, r[31:24]);
            pin <= r[21];
            rd(XAS_ADDR_SYSTEM_CTRL, v);
            check(v, sc);
            mv(q[0], q[1], q[15:8], q[23:16]);
            check(active_data_pointer_out, ptr[sel]);
        end
        // only a reset may bring the disable bit back
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        {sc, pg, sel} = {XAS_SYSCTRL_RESET, XAS_PAGE_RESET, XAS_PSEL_RESET};
        foreach (ptr[k]) ptr[k] = XAS_DATA_POINTER_RESET;
        rd(XAS_ADDR_SYSTEM_CTRL, v);
        check(v, XAS_SYSCTRL_RESET);
        wr(XAS_ADDR_DATA_POINTER_HIGH, 8'hF8);
        mv(1'b1, 1'b1, 8'h00, 8'h3C);
        check(active_data_pointer_out, ptr[0]);
        report_and_stop();
    end
endmodule
`default_nettype wire
